//--- logic/hbds_defs.svh
// Constants for the parallel bus data and strobe control block.
// Assumes inclusion by the package and both bus ends.
`ifndef HBDS_DEFS_SVH
`define HBDS_DEFS_SVH

// ----------------------------------------------------------------
// Bus styles
// ----------------------------------------------------------------
`define HBDS_STYLE_NARROW 2'h1

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HBDS_CLK_MHZ      25
`define HBDS_STROBE_NS    400
`define HBDS_STROBE_CYC   ((`HBDS_STROBE_NS * `HBDS_CLK_MHZ + 999) / 1000)
`define HBDS_SYNC_STAGES  3

// ----------------------------------------------------------------
// Reset values and data lane enable patterns
// ----------------------------------------------------------------
`define HBDS_PIN_IDLE     1'b1
`define HBDS_DATA_IDLE    16'hFFFF
`define HBDS_OE_OFF       16'hFFFF
`define HBDS_OE_LOW_ONLY  16'hFF00
`define HBDS_OE_ALL       16'h0000

`endif

//--- logic/hbds_pkg.sv
// Types shared by both ends of the parallel bus.
// Assumes the constants header sits beside it.
package hbds_pkg;
    `include "hbds_defs.svh"

    typedef logic [1:0]  hbds_style_t;
    typedef logic [15:0] hbds_word_t;

    typedef enum logic [1:0] {
        HBDS_IDLE,
        HBDS_STROBE,
        HBDS_RECOVER
    } hbds_cyc_e;
endpackage

//--- logic/hbds_bus_if.sv
// Shared parallel bus pins between the device end and the far end.
// Assumes both ends run on mclk; undriven lines read high (pull-ups).
`timescale 1ns/100ps
interface hbds_bus_if;
    logic [15:0] devData;
    logic [15:0] devDataOe_n;
    logic        devRd;
    logic        devRdOe_n;
    logic        devWr;
    logic        devWrOe_n;
    logic        devLsb;
    logic        devLsbOe_n;
    logic [15:0] hostData;
    logic [15:0] hostDataOe_n;
    logic        hostRd;
    logic        hostRdOe_n;
    logic        hostWr;
    logic        hostWrOe_n;
    logic        hostLsb;
    logic        hostLsbOe_n;
    logic [15:0] dataBus;
    logic        rdPin;
    logic        wrPin;
    logic        lsbPin;

    // ----------------------------------------------------------------
    // Wire resolution
    // ----------------------------------------------------------------
    // Pull-ups make a floating line read high
    assign dataBus = (~devDataOe_n & devData) | (~hostDataOe_n & hostData) | (devDataOe_n & hostDataOe_n);
    assign rdPin   = devRdOe_n ? (hostRdOe_n ? 1'b1 : hostRd) : devRd;
    assign wrPin   = devWrOe_n ? (hostWrOe_n ? 1'b1 : hostWr) : devWr;
    assign lsbPin  = devLsbOe_n ? (hostLsbOe_n ? 1'b1 : hostLsb) : devLsb;

    modport device (
        output devData, devDataOe_n, devRd, devRdOe_n, devWr, devWrOe_n, devLsb, devLsbOe_n,
        input  dataBus, rdPin, wrPin, lsbPin
    );
    modport host (
        output hostData, hostDataOe_n, hostRd, hostRdOe_n, hostWr, hostWrOe_n, hostLsb, hostLsbOe_n,
        input  dataBus, rdPin, wrPin, lsbPin
    );
endinterface

//--- logic/hbds_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes idle pin level is high.
`timescale 1ns/100ps
module hbds_sync
#(
    parameter int W = 19
)
(
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pinIn,
    output logic      [W-1:0] level
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] level_r;

    // Level updates only per bit where stages two and three agree
    wire  [W-1:0] agree = ~(s2_r ^ s3_r);
    wire  [W-1:0] level_nxt = (agree & s2_r) | (~agree & level_r);

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_r    <= '1;
            s2_r    <= '1;
            s3_r    <= '1;
            level_r <= '1;
        end
        else
        begin
            s1_r    <= pinIn;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            level_r <= level_nxt;
        end
    end

    assign level = level_r;
endmodule

//--- logic/hbds_device.sv
// Device end: data bus, read, write and low address/strobe pin control.
// Assumes the far end keeps its own pin duties; all on mclk.
//
// Contract
// - Data 0-7 are low byte, all styles
// - Data 8-15 high byte in styles 0,2,3
// - Master styles 0/1: read strobe out, sample data
// - Slave styles 0/1: host read low, device drives
// - Master styles 0/1: write strobe out, drive data
// - Slave styles 0/1: host write low, device accepts
// - Master styles 2/3: direction out, high means inward
// - Slave styles 2/3: direction in, high device outputs
// - Styles 0/1: shared pin is address LSB
// - Styles 2/3: shared pin is data strobe for all lanes, active low
// - Styles 2/3: read pin unused, reads high
`timescale 1ns/100ps
`include "hbds_defs.svh"
module hbds_device
    import hbds_pkg::*;
(
    input  wire logic   mclk,
    input  wire logic   rst_n,
    hbds_bus_if.device  bus,
    input  wire hbds_style_t busStyle,
    input  wire logic   masterMode,
    input  wire logic   sysStop,
    input  wire logic   mReq,
    input  wire logic   mWrite,
    input  wire logic   mAddrLsb,
    input  wire hbds_word_t mWdata,
    output hbds_word_t  mRdata,
    output logic        mDone,
    input  wire hbds_word_t slvRdata,
    output logic        slvRdStb,
    output logic        slvWrStb,
    output logic        slvAddrLsb,
    output hbds_word_t  slvWdata
);
    localparam int STB = `HBDS_STROBE_CYC;

    hbds_cyc_e   state_r;
    logic [7:0]  cnt_r;
    logic        write_r;
    logic        lsb_r;
    hbds_word_t  wdata_r;
    hbds_word_t  mRdata_r;
    logic        mDone_r;
    logic        sWrPrev_r;
    logic        sRdPrev_r;
    hbds_word_t  slvWdata_r;
    logic        slvAddrLsb_r;
    logic        slvRdStb_r;
    logic        slvWrStb_r;
    hbds_word_t  dOut_r;
    hbds_word_t  dOe_n_r;
    logic        rd_r;
    logic        rdOe_n_r;
    logic        wr_r;
    logic        wrOe_n_r;
    logic        lsbOut_r;
    logic        lsbOe_n_r;
    logic [18:0] syncOut;

    // ----------------------------------------------------------------
    // Pin sampling
    // ----------------------------------------------------------------
    hbds_sync #(.W(19)) uSync
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .pinIn ({bus.rdPin, bus.wrPin, bus.lsbPin, bus.dataBus}),
        .level (syncOut)
    );

    wire        rdL     = syncOut[18];
    wire        wrL     = syncOut[17];
    wire        lsbL    = syncOut[16];
    wire [15:0] dIn     = syncOut[15:0];
    wire        style01 = ~busStyle[1];
    wire        wide    = busStyle != `HBDS_STYLE_NARROW;
    wire        master  = ~sysStop & masterMode;
    wire        slave   = ~sysStop & ~masterMode;
    // High lanes stay off in the narrow style
    wire [15:0] laneOe_n = wide ? `HBDS_OE_ALL : `HBDS_OE_LOW_ONLY;

    // ----------------------------------------------------------------
    // Slave decode
    // ----------------------------------------------------------------
    wire sRead  = slave & (style01 ? ~rdL : (wrL & ~lsbL));
    wire sWrite = slave & (style01 ? ~wrL : (~wrL & ~lsbL));
    wire sWrEnd = sWrPrev_r & ~sWrite;
    wire sRdBeg = sRead & ~sRdPrev_r;

    // ----------------------------------------------------------------
    // Master cycle
    // ----------------------------------------------------------------
    wire inStb   = state_r == HBDS_STROBE;
    wire lastStb = inStb && cnt_r == 8'(STB - 1);
    wire start   = state_r == HBDS_IDLE && master && mReq;
    wire recov   = state_r == HBDS_RECOVER;

    // Pin drive decode
    wire        rd_nxt     = ~(inStb & ~write_r);
    wire        rdOe_n_nxt = ~(master & style01);
    wire        wr_nxt     = ~(inStb & write_r);
    wire        wrOe_n_nxt = ~master;
    wire        lsb_nxt    = style01 ? lsb_r : ~inStb;
    wire        lsbOe_n_nxt = ~master;
    wire [15:0] dOe_n_nxt  = (master & inStb & write_r) | sRead ? laneOe_n : `HBDS_OE_OFF;
    wire [15:0] dOut_nxt   = master ? wdata_r : slvRdata;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= HBDS_IDLE;
            cnt_r   <= 8'h00;
            write_r <= 1'b0;
            lsb_r   <= 1'b0;
            wdata_r <= 16'h0000;
        end
        else
        begin
            unique case (state_r)
                HBDS_IDLE:
                begin
                    if (start)
                    begin
                        state_r <= HBDS_STROBE;
                        write_r <= mWrite;
                        lsb_r   <= mAddrLsb;
                        wdata_r <= mWdata;
                        cnt_r   <= 8'h00;
                    end
                end
                HBDS_STROBE:
                begin
                    cnt_r <= cnt_r + 8'h01;
                    if (lastStb)
                        state_r <= HBDS_RECOVER;
                end
                HBDS_RECOVER:
                    state_r <= HBDS_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mRdata_r     <= 16'h0000;
            mDone_r      <= 1'b0;
            sWrPrev_r    <= 1'b0;
            sRdPrev_r    <= 1'b0;
            slvWdata_r   <= 16'h0000;
            slvAddrLsb_r <= 1'b0;
            slvRdStb_r   <= 1'b0;
            slvWrStb_r   <= 1'b0;
        end
        else
        begin
            // Sample in recovery: far-end data crosses two filters
            if (recov && !write_r)
                mRdata_r <= wide ? dIn : {8'h00, dIn[7:0]};
            mDone_r    <= recov;
            sWrPrev_r  <= sWrite;
            sRdPrev_r  <= sRead;
            if (sWrite)
            begin
                slvWdata_r   <= wide ? dIn : {8'h00, dIn[7:0]};
                slvAddrLsb_r <= style01 ? lsbL : 1'b0;
            end
            else if (sRdBeg)
                slvAddrLsb_r <= style01 ? lsbL : 1'b0;
            slvRdStb_r <= sRdBeg;
            slvWrStb_r <= sWrEnd;
        end
    end

    // ----------------------------------------------------------------
    // Pin registers
    // ----------------------------------------------------------------
    // All drivers off under reset; inputs only
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dOut_r    <= `HBDS_DATA_IDLE;
            dOe_n_r   <= `HBDS_OE_OFF;
            rd_r      <= `HBDS_PIN_IDLE;
            rdOe_n_r  <= 1'b1;
            wr_r      <= `HBDS_PIN_IDLE;
            wrOe_n_r  <= 1'b1;
            lsbOut_r  <= `HBDS_PIN_IDLE;
            lsbOe_n_r <= 1'b1;
        end
        else
        begin
            dOut_r    <= dOut_nxt;
            dOe_n_r   <= dOe_n_nxt;
            rd_r      <= rd_nxt;
            rdOe_n_r  <= rdOe_n_nxt;
            wr_r      <= wr_nxt;
            wrOe_n_r  <= wrOe_n_nxt;
            lsbOut_r  <= lsb_nxt;
            lsbOe_n_r <= lsbOe_n_nxt;
        end
    end

    assign bus.devData     = dOut_r;
    assign bus.devDataOe_n = dOe_n_r;
    assign bus.devRd       = rd_r;
    assign bus.devRdOe_n   = rdOe_n_r;
    assign bus.devWr       = wr_r;
    assign bus.devWrOe_n   = wrOe_n_r;
    assign bus.devLsb      = lsbOut_r;
    assign bus.devLsbOe_n  = lsbOe_n_r;
    assign mRdata          = mRdata_r;
    assign mDone           = mDone_r;
    assign slvRdStb        = slvRdStb_r;
    assign slvWrStb        = slvWrStb_r;
    assign slvAddrLsb      = slvAddrLsb_r;
    assign slvWdata        = slvWdata_r;
endmodule

//--- logic/hbds_host.sv
// Far end: host processor when the device is slave, memory when master.
// Assumes the device end keeps its pin duties; all on mclk.
`timescale 1ns/100ps
`include "hbds_defs.svh"
module hbds_host
    import hbds_pkg::*;
(
    input  wire logic   mclk,
    input  wire logic   rst_n,
    hbds_bus_if.host    bus,
    input  wire hbds_style_t busStyle,
    input  wire logic   devMaster,
    input  wire logic   cReq,
    input  wire logic   cWrite,
    input  wire logic   cAddrLsb,
    input  wire hbds_word_t cWdata,
    output hbds_word_t  cRdata,
    output logic        cDone,
    input  wire hbds_word_t memRdata,
    output logic        memRdStb,
    output logic        memWrStb,
    output logic        memAddrLsb,
    output hbds_word_t  memWdata
);
    localparam int STB = `HBDS_STROBE_CYC;

    hbds_cyc_e   state_r;
    logic [7:0]  cnt_r;
    logic        write_r;
    logic        lsb_r;
    hbds_word_t  wdata_r;
    hbds_word_t  cRdata_r;
    logic        cDone_r;
    logic        wPrev_r;
    logic        rPrev_r;
    hbds_word_t  memWdata_r;
    logic        memAddrLsb_r;
    logic        memRdStb_r;
    logic        memWrStb_r;
    hbds_word_t  dOut_r;
    hbds_word_t  dOe_n_r;
    logic        rd_r;
    logic        rdOe_n_r;
    logic        wr_r;
    logic        wrOe_n_r;
    logic        lsbOut_r;
    logic        lsbOe_n_r;
    logic [18:0] syncOut;

    // ----------------------------------------------------------------
    // Pin sampling
    // ----------------------------------------------------------------
    hbds_sync #(.W(19)) uSync
    (
        .mclk  (mclk),
        .rst_n (rst_n),
        .pinIn ({bus.rdPin, bus.wrPin, bus.lsbPin, bus.dataBus}),
        .level (syncOut)
    );

    wire        rdL      = syncOut[18];
    wire        wrL      = syncOut[17];
    wire        lsbL     = syncOut[16];
    wire [15:0] dIn      = syncOut[15:0];
    wire        style01  = ~busStyle[1];
    wire        wide     = busStyle != `HBDS_STYLE_NARROW;
    wire        cpu      = ~devMaster;
    wire [15:0] laneOe_n = wide ? `HBDS_OE_ALL : `HBDS_OE_LOW_ONLY;

    // ----------------------------------------------------------------
    // Memory role: answer the device's cycles
    // ----------------------------------------------------------------
    wire mRead  = devMaster & (style01 ? ~rdL : (wrL & ~lsbL));
    wire mWrite = devMaster & (style01 ? ~wrL : (~wrL & ~lsbL));

    // ----------------------------------------------------------------
    // Processor role
    // ----------------------------------------------------------------
    wire inStb   = state_r == HBDS_STROBE;
    wire lastStb = inStb && cnt_r == 8'(STB - 1);
    wire start   = state_r == HBDS_IDLE && cpu && cReq;
    wire recov   = state_r == HBDS_RECOVER;

    wire        rd_nxt      = ~(inStb & ~write_r);
    wire        rdOe_n_nxt  = ~(cpu & style01);
    wire        wr_nxt      = ~(inStb & write_r);
    wire        wrOe_n_nxt  = ~cpu;
    wire        lsb_nxt     = style01 ? lsb_r : ~inStb;
    wire        lsbOe_n_nxt = ~cpu;
    wire [15:0] dOe_n_nxt   = (cpu & inStb & write_r) | mRead ? laneOe_n : `HBDS_OE_OFF;
    wire [15:0] dOut_nxt    = cpu ? wdata_r : memRdata;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r <= HBDS_IDLE;
            cnt_r   <= 8'h00;
            write_r <= 1'b0;
            lsb_r   <= 1'b0;
            wdata_r <= 16'h0000;
        end
        else
        begin
            unique case (state_r)
                HBDS_IDLE:
                begin
                    if (start)
                    begin
                        state_r <= HBDS_STROBE;
                        write_r <= cWrite;
                        lsb_r   <= cAddrLsb;
                        wdata_r <= cWdata;
                        cnt_r   <= 8'h00;
                    end
                end
                HBDS_STROBE:
                begin
                    cnt_r <= cnt_r + 8'h01;
                    if (lastStb)
                        state_r <= HBDS_RECOVER;
                end
                HBDS_RECOVER:
                    state_r <= HBDS_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cRdata_r     <= 16'h0000;
            cDone_r      <= 1'b0;
            wPrev_r      <= 1'b0;
            rPrev_r      <= 1'b0;
            memWdata_r   <= 16'h0000;
            memAddrLsb_r <= 1'b0;
            memRdStb_r   <= 1'b0;
            memWrStb_r   <= 1'b0;
        end
        else
        begin
            // Sample in recovery: device data crosses two filters
            if (recov && !write_r)
                cRdata_r <= wide ? dIn : {8'h00, dIn[7:0]};
            cDone_r <= recov;
            wPrev_r <= mWrite;
            rPrev_r <= mRead;
            if (mWrite)
                memWdata_r <= wide ? dIn : {8'h00, dIn[7:0]};
            if (mWrite || (mRead && !rPrev_r))
                memAddrLsb_r <= style01 ? lsbL : 1'b0;
            memRdStb_r <= mRead & ~rPrev_r;
            memWrStb_r <= wPrev_r & ~mWrite;
        end
    end

    // ----------------------------------------------------------------
    // Pin registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dOut_r    <= `HBDS_DATA_IDLE;
            dOe_n_r   <= `HBDS_OE_OFF;
            rd_r      <= `HBDS_PIN_IDLE;
            rdOe_n_r  <= 1'b1;
            wr_r      <= `HBDS_PIN_IDLE;
            wrOe_n_r  <= 1'b1;
            lsbOut_r  <= `HBDS_PIN_IDLE;
            lsbOe_n_r <= 1'b1;
        end
        else
        begin
            dOut_r    <= dOut_nxt;
            dOe_n_r   <= dOe_n_nxt;
            rd_r      <= rd_nxt;
            rdOe_n_r  <= rdOe_n_nxt;
            wr_r      <= wr_nxt;
            wrOe_n_r  <= wrOe_n_nxt;
            lsbOut_r  <= lsb_nxt;
            lsbOe_n_r <= lsbOe_n_nxt;
        end
    end

    assign bus.hostData     = dOut_r;
    assign bus.hostDataOe_n = dOe_n_r;
    assign bus.hostRd       = rd_r;
    assign bus.hostRdOe_n   = rdOe_n_r;
    assign bus.hostWr       = wr_r;
    assign bus.hostWrOe_n   = wrOe_n_r;
    assign bus.hostLsb      = lsbOut_r;
    assign bus.hostLsbOe_n  = lsbOe_n_r;
    assign cRdata           = cRdata_r;
    assign cDone            = cDone_r;
    assign memRdStb         = memRdStb_r;
    assign memWrStb         = memWrStb_r;
    assign memAddrLsb       = memAddrLsb_r;
    assign memWdata         = memWdata_r;
endmodule

//--- testbench/hbds_properties.sv
// Concurrent checks on the shared bus pins between both ends.
// Assumes one clock; instantiated beside the interface by the bench.
`timescale 1ns/100ps
module hbds_properties
    import hbds_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire hbds_style_t busStyle,
    input wire logic        masterMode,
    input wire logic        sysStop,
    input wire logic [15:0] devDataOe_n,
    input wire logic        devRd,
    input wire logic        devRdOe_n,
    input wire logic        devWr,
    input wire logic        devWrOe_n,
    input wire logic        devLsb,
    input wire logic        devLsbOe_n,
    input wire logic        rdPin,
    input wire logic        wrPin,
    input wire logic        lsbPin
);
    // ----------------------------------------------------------------
    // Pin duties
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_stop_all_free: assert property (sysStop && $past(sysStop) |-> &{devDataOe_n, devRdOe_n, devWrOe_n, devLsbOe_n})
        else $error("pins driven during stop");
    chk_narrow_hi_free: assert property (busStyle == 2'h1 && $stable(busStyle) |-> devDataOe_n[15:8] == 8'hFF)
        else $error("high byte driven in narrow style");
    chk_rd_pin_unused: assert property (busStyle[1] && $stable(busStyle) |-> devRdOe_n)
        else $error("read pin driven in styles 2/3");
    chk_master_rd_in: assert property (masterMode && !devRdOe_n && !devRd |-> devDataOe_n == 16'hFFFF)
        else $error("data driven during own read");
    chk_strobe_ten_long: assert property (masterMode && !devRdOe_n && $fell(devRd) |-> !devRd [*8] ##1 !devRd [*2] ##1 devRd)
        else $error("read strobe length wrong");
    chk_master_wr_out: assert property (masterMode && busStyle == 2'h0 && !devWrOe_n && !devWr |-> devDataOe_n == 16'h0000)
        else $error("data not driven during own write");
    chk_dir_follows_oe: assert property (masterMode && busStyle[1] && !devLsbOe_n && !devLsb |-> !devWrOe_n && devWr == devDataOe_n[0])
        else $error("direction pin disagrees with data drive");
    chk_slave_rd_drive: assert property ((!masterMode && !sysStop && !busStyle[1] && !rdPin) [*7] |-> devDataOe_n[7:0] == 8'h00)
        else $error("no data for host read");
    chk_slave_wr_float: assert property ((!masterMode && !busStyle[1] && !wrPin) [*2] |-> devDataOe_n == 16'hFFFF)
        else $error("data driven during host write");
    chk_rw_high_drive: assert property ((!masterMode && !sysStop && busStyle[1] && wrPin && !lsbPin) [*7] |-> devDataOe_n[7:0] == 8'h00)
        else $error("no data for host read in styles 2/3");
    chk_rw_low_float: assert property ((!masterMode && busStyle[1] && !wrPin && !lsbPin) [*2] |-> devDataOe_n == 16'hFFFF)
        else $error("data driven during host write in styles 2/3");

    cover property (masterMode && $fell(devRd));
    cover property (!masterMode && $fell(wrPin));
    cover property (sysStop && $past(sysStop));
endmodule

//--- testbench/host_bus_data_strobe_control_tb.sv
// Bench joining the device end and the far end through the shared bus.
// Assumes design files under logic/; inputs change on the falling edge.
`timescale 1ns/100ps
module host_bus_data_strobe_control_tb;
    import hbds_pkg::*;
    logic        mclk = 0, rst_n = 0, masterMode = 1, sysStop = 0;
    hbds_style_t busStyle = 2'h0;
    logic        mReq = 0, mWrite = 0, mAddrLsb = 0, mDone, slvRdStb, slvWrStb, slvAddrLsb;
    logic        cReq = 0, cWrite = 0, cAddrLsb = 0, cDone, memRdStb, memWrStb, memAddrLsb;
    hbds_word_t  mWdata = 0, mRdata, slvRdata = 0, slvWdata, cWdata = 0, cRdata, memRdata = 0, memWdata;
    int          fails = 0, total_checks = 0, cycles = 0, wrN = 0, rdN = 0;
    logic [16:0] wrLast;
    logic        rdLsb = 0;

    hbds_bus_if hbds_bus_if_i ();
    hbds_device hbds_device_i (.mclk(mclk), .rst_n(rst_n), .bus(hbds_bus_if_i.device), .busStyle(busStyle),
        .masterMode(masterMode), .sysStop(sysStop), .mReq(mReq), .mWrite(mWrite), .mAddrLsb(mAddrLsb),
        .mWdata(mWdata), .mRdata(mRdata), .mDone(mDone), .slvRdata(slvRdata), .slvRdStb(slvRdStb),
        .slvWrStb(slvWrStb), .slvAddrLsb(slvAddrLsb), .slvWdata(slvWdata));
    hbds_host hbds_host_i (.mclk(mclk), .rst_n(rst_n), .bus(hbds_bus_if_i.host), .busStyle(busStyle),
        .devMaster(masterMode), .cReq(cReq), .cWrite(cWrite), .cAddrLsb(cAddrLsb), .cWdata(cWdata),
        .cRdata(cRdata), .cDone(cDone), .memRdata(memRdata), .memRdStb(memRdStb), .memWrStb(memWrStb),
        .memAddrLsb(memAddrLsb), .memWdata(memWdata));
    hbds_properties hbds_properties_i (.mclk(mclk), .rst_n(rst_n), .busStyle(busStyle),
        .masterMode(masterMode), .sysStop(sysStop), .devDataOe_n(hbds_bus_if_i.devDataOe_n),
        .devRd(hbds_bus_if_i.devRd), .devRdOe_n(hbds_bus_if_i.devRdOe_n), .devWr(hbds_bus_if_i.devWr),
        .devWrOe_n(hbds_bus_if_i.devWrOe_n), .devLsb(hbds_bus_if_i.devLsb),
        .devLsbOe_n(hbds_bus_if_i.devLsbOe_n), .rdPin(hbds_bus_if_i.rdPin), .wrPin(hbds_bus_if_i.wrPin),
        .lsbPin(hbds_bus_if_i.lsbPin));

    // ----------------------------------------------------------------
    // Clock, watchdog, write capture
    // ----------------------------------------------------------------
    always #20 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles++;
        if (memWrStb | slvWrStb)
        begin
            wrN++;
            wrLast = memWrStb ? {memAddrLsb, memWdata} : {slvAddrLsb, slvWdata};
        end
        if (memRdStb | slvRdStb)
        begin
            rdN++;
            rdLsb = memRdStb ? memAddrLsb : slvAddrLsb;
        end
        if (cycles == 20000)
        begin
            fails++;
            wrap_up;
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wrap_up;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One word across the bus; the far end of the chosen master answers
    task xfer(input logic hostSide, input logic wr, input logic lsb, input hbds_word_t d);
        hbds_word_t ex;
        int         n;
        int         k;
        int         kr;
        ex = (busStyle == 2'h1) ? {8'h00, d[7:0]} : d;
        @(negedge mclk);
        memRdata = d;
        slvRdata = d;
        k = wrN;
        kr = rdN;
        {mWrite, mAddrLsb, mWdata, cWrite, cAddrLsb, cWdata} = {wr, lsb, d, wr, lsb, d};
        mReq = !hostSide;
        cReq = hostSide;
        n = 0;
        do
        begin
            @(posedge mclk);
            #1;
            n++;
        end while (!(hostSide ? cDone : mDone) && n < 40);
        check(n, 12);
        if (!wr)
        begin
            check(hostSide ? cRdata : mRdata, ex);
            check(rdN - kr, 1);
            check(rdLsb, busStyle[1] ? 1'b0 : lsb);
        end
        @(negedge mclk);
        mReq = 0;
        cReq = 0;
        n = 0;
        while (wr && wrN == k && n < 16)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (wr)
            check(wrLast, {busStyle[1] ? 1'b0 : lsb, ex});
        repeat (12) @(negedge mclk);
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (13) @(negedge mclk);
        rst_n = 1;
        repeat (6) @(negedge mclk);
        for (int s = 0; s < 4; s++)
        begin
            busStyle = s[1:0];
            for (int h = 0; h < 2; h++)
            begin
                masterMode = (h == 0);
                repeat (6) @(negedge mclk);
                xfer(h[0], 1'b0, 1'b1, 16'hA55A ^ s[15:0]);
                xfer(h[0], 1'b1, 1'b0, 16'h3CC3 + s[15:0]);
                xfer(h[0], 1'b1, 1'b1, 16'hF00F);
                xfer(h[0], 1'b0, 1'b0, 16'h0FF0);
            end
            $display("style %0d test done", s);
        end
        // Stop: a pending request must stay unanswered and pins released
        masterMode = 1;
        busStyle = 2'h0;
        sysStop = 1;
        repeat (4) @(negedge mclk);
        mReq = 1;
        begin
            int n;
            n = 0;
            repeat (30)
            begin
                @(posedge mclk);
                #1;
                n += mDone;
            end
            check(n, 0);
        end
        check({hbds_bus_if_i.devDataOe_n, hbds_bus_if_i.devRdOe_n, hbds_bus_if_i.devWrOe_n,
            hbds_bus_if_i.devLsbOe_n}, 32'h7FFFF);
        @(negedge mclk);
        mReq = 0;
        sysStop = 0;
        repeat (6) @(negedge mclk);
        $display("stop test done");
        // Reset in mid transfer, then a clean transfer after it
        mReq = 1;
        repeat (5) @(negedge mclk);
        rst_n = 0;
        mReq = 0;
        #1;
        check({hbds_bus_if_i.devDataOe_n, hbds_bus_if_i.devRdOe_n, hbds_bus_if_i.devWrOe_n,
            hbds_bus_if_i.devLsbOe_n, mDone}, 32'hFFFFE);
        repeat (3) @(negedge mclk);
        rst_n = 1;
        repeat (6) @(negedge mclk);
        xfer(1'b0, 1'b0, 1'b1, 16'h1234);
        $display("reset test done");
        wrap_up;
    end
endmodule
